// [src/fwff_pkg.sv]
// constants, register map and structs of the fifo flag block
package fwff_pkg;

    // register map, byte addresses on the avalon slave
    localparam int unsigned BUS_AW        = 5;
    localparam int unsigned BUS_DW        = 32;
    localparam logic [4:0]  REG_CTRL      = 5'h00;
    localparam logic [4:0]  REG_EMPTY_OFS = 5'h04;
    localparam logic [4:0]  REG_FULL_OFS  = 5'h08;
    localparam logic [4:0]  REG_STATUS    = 5'h0c;
    localparam logic [4:0]  REG_COUNT     = 5'h10;

    // control register: selects what the parallel data output shows
    localparam int unsigned CTRL_VIEW_LSB = 0;
    localparam int unsigned CTRL_VIEW_W   = 2;
    localparam logic [1:0]  VIEW_FIFO     = 2'h0;
    localparam logic [1:0]  VIEW_EMPTY    = 2'h1;
    localparam logic [1:0]  VIEW_FULL     = 2'h2;

    // status register field positions
    localparam int unsigned ST_IR_N       = 0;
    localparam int unsigned ST_OR_N       = 1;
    localparam int unsigned ST_HF_N       = 2;
    localparam int unsigned ST_AF_N       = 3;
    localparam int unsigned ST_AE_N       = 4;
    localparam int unsigned ST_FALL_THROUGH_MODE       = 5;
    localparam int unsigned ST_SERIAL     = 6;

    // offset registers
    localparam int unsigned OFS_W         = 16;
    localparam int unsigned SHALLOW_MAX   = 2048;
    localparam logic [15:0] OFS_1023      = 16'h03ff;
    localparam logic [15:0] OFS_511       = 16'h01ff;
    localparam logic [15:0] OFS_255       = 16'h00ff;
    localparam logic [15:0] OFS_127       = 16'h007f;
    localparam logic [15:0] OFS_63        = 16'h003f;
    localparam logic [15:0] OFS_31        = 16'h001f;
    localparam logic [15:0] OFS_15        = 16'h000f;
    localparam logic [15:0] OFS_7         = 16'h0007;
    localparam logic [15:0] OFS_3         = 16'h0003;

    // reset-time configuration when only rst_in acts
    localparam logic        RST_FALL_THROUGH_MODE      = 1'b1;
    localparam logic        RST_SERIAL    = 1'b0;
    localparam logic [1:0]  RST_SEL       = 2'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ANS  = 2'b10
    } fwff_bus_e;

    typedef struct packed {
        logic wclk;
        logic rclk;
        logic write_en_n;
        logic read_en_n;
        logic master_reset_n;
        logic timing_mode_select;
        logic offset_load_select;
        logic offset_select_hi;
        logic offset_select_lo;
    } fwff_pins_s;

    typedef struct packed {
        logic       fall_through_mode;
        logic       serial_load;
        logic [1:0] offset_sel;
    } fwff_cfg_s;

    typedef struct packed {
        logic ir_n;
        logic or_n;
        logic hf_n;
        logic af_n;
        logic ae_n;
    } fwff_flags_s;

    // empty fifo flag pattern: input ready, output not ready, almost empty
    localparam fwff_flags_s FLAGS_EMPTY = '{ir_n: 1'b0, or_n: 1'b1, hf_n: 1'b1, af_n: 1'b1, ae_n: 1'b0};

    // default offset picked by load select and the two offset selects
    function automatic logic [15:0] default_offset(input logic ld, input logic [1:0] sel, input logic deep);
        logic [15:0] v;
        v = OFS_127;
        case ({ld, sel})
            3'b010:  v = OFS_511;
            3'b001:  v = OFS_255;
            3'b000:  v = OFS_127;
            3'b011:  v = OFS_63;
            3'b100:  v = deep ? OFS_1023 : OFS_31;
            3'b110:  v = deep ? OFS_31 : OFS_15;
            3'b101:  v = deep ? OFS_15 : OFS_7;
            3'b111:  v = deep ? OFS_7 : OFS_3;
            default: v = OFS_127;
        endcase
        return v;
    endfunction : default_offset

endpackage : fwff_pkg

// [src/fwff_top.sv]
// fall-through fifo: flags, default offsets, staging buffer, register slave

module fwff_stage_fifo #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clear_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
        $error("stage fifo depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
    } fwff_sf_s;

    fwff_sf_s s_q, s_d;
    logic     push, pop;

    assign in_ready_out  = (s_q.cnt != (PW+1)'(DEPTH));
    assign out_valid_out = (s_q.cnt != '0);
    assign out_data_out  = s_q.mem[s_q.rp];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wp] = in_data_in;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (pop)
        begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
        if (clear_in)
        begin
            s_d.wp  = '0;
            s_d.rp  = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end
endmodule : fwff_stage_fifo

// Notes on behaviour
// - timing select high at reset picks fall-through
// - write enable low stores data each write edge
// - output ready low once first word lands
// - almost empty high at count offset plus two
// - half full low at half depth plus two
// - almost full low at depth+1 minus offset
// - input ready high at depth+1 words; writes ignored
// - output holding register counts as a location
// - reads from full release flags at thresholds
// - almost empty low at offset plus one
// - output ready high when drained; reads ignored
// - output ready three stages, input ready two
// - reset loads one of eight default offsets
// - load select at reset picks serial/parallel mode
// - offsets read back only on data output
// - offsets rewritable anytime, range zero to depth-1
// - empty offset feeds almost empty, full offset almost full
module fwff_top #(
    parameter int unsigned WIDTH       = 36,
    parameter int unsigned DEPTH       = 1024,
    parameter int unsigned STAGE_DEPTH = 4
) (
    input  wire logic                          core_clk_in,
    input  wire logic                          rst_in,
    input  wire logic                          write_clk_in,
    input  wire logic                          read_clk_in,
    input  wire logic                          write_en_n_in,
    input  wire logic                          read_en_n_in,
    input  wire logic [WIDTH-1:0]              write_data_in,
    input  wire logic                          master_reset_n_in,
    input  wire logic                          timing_mode_select_in,
    input  wire logic                          offset_load_select_in,
    input  wire logic                          offset_select_hi_in,
    input  wire logic                          offset_select_lo_in,
    input  wire logic [fwff_pkg::BUS_AW-1:0]   avs_address_in,
    input  wire logic                          avs_read_in,
    input  wire logic                          avs_write_in,
    input  wire logic [fwff_pkg::BUS_DW-1:0]   avs_writedata_in,
    input  wire logic [3:0]                    avs_byteenable_in,
    output logic [fwff_pkg::BUS_DW-1:0]        avs_readdata_out,
    output logic                               avs_waitrequest_out,
    output logic [WIDTH-1:0]                   read_data_out,
    output logic                               input_ready_n_out,
    output logic                               output_ready_n_out,
    output logic                               half_full_flag_n_out,
    output logic                               almost_full_flag_n_out,
    output logic                               almost_empty_flag_n_out
);
    localparam int unsigned AW   = $clog2(DEPTH);
    localparam int unsigned CW   = $clog2(DEPTH + 2) + 1;
    localparam logic        DEEP = (DEPTH > fwff_pkg::SHALLOW_MAX);
    localparam logic [CW-1:0] CAP     = CW'(DEPTH + 1);
    localparam logic [CW-1:0] HALF_AT = CW'(DEPTH / 2 + 2);

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 32768 || WIDTH < 16 || WIDTH > 36)
    begin : g_chk
        $error("depth must be a power of two from 4 to 32768 and width 16 to 36");
    end

    typedef struct packed {
        fwff_pkg::fwff_pins_s        p1;
        fwff_pkg::fwff_pins_s        p2;
        logic [WIDTH-1:0]            d1;
        logic [WIDTH-1:0]            d2;
        logic                        wclk_prev;
        logic                        rclk_prev;
        fwff_pkg::fwff_cfg_s         cfg;
        logic [15:0]                 empty_ofs;
        logic [15:0]                 full_ofs;
        logic [1:0]                  view;
        logic [CW-1:0]               wcnt;
        logic [CW-1:0]               mwr;
        logic [CW-1:0]               hcnt;
        logic [CW-1:0]               rcnt;
        logic [CW-1:0]               rcnt_w1;
        logic [CW-1:0]               rcnt_w2;
        logic [CW-1:0]               wcnt_r1;
        logic [CW-1:0]               wcnt_r2;
        logic [CW-1:0]               mwr_r1;
        logic [CW-1:0]               mwr_r2;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            hold;
        logic                        hold_valid;
        fwff_pkg::fwff_flags_s       flags;
        logic [WIDTH-1:0]            q;
        fwff_pkg::fwff_bus_e         bus;
        logic [31:0]                 rdata;
        logic                        waitreq;
    } fwff_st_s;

    fwff_st_s              s_q, s_d;
    fwff_pkg::fwff_pins_s  pins;
    logic                  stage_in_ready, stage_out_valid, stage_out_ready;
    logic [WIDTH-1:0]      stage_out_data;
    logic                  wr_edge, rd_edge, accept, rd_take, mr_active;
    logic [CW-1:0]         count_w, count_r;

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    assign pins = '{write_clk_in, read_clk_in, write_en_n_in, read_en_n_in, master_reset_n_in,
                    timing_mode_select_in, offset_load_select_in, offset_select_hi_in, offset_select_lo_in};

    // edges are found on the second sync stage only, never on the first
    assign wr_edge   = s_q.p2.wclk && !s_q.wclk_prev;
    assign rd_edge   = s_q.p2.rclk && !s_q.rclk_prev;
    assign mr_active = !s_q.p2.master_reset_n;
    // writes are dropped while full or while the stage cannot take them
    assign accept    = wr_edge && !s_q.p2.write_en_n && !s_q.flags.ir_n && stage_in_ready;
    assign rd_take   = rd_edge && !s_q.p2.read_en_n && s_q.hold_valid;
    // each side judges the count with the other side's counter resynchronised
    assign count_w   = s_q.wcnt - s_q.rcnt_w2;
    assign count_r   = s_q.wcnt_r2 - s_q.rcnt;
    // the main memory is drained into while it has a free slot
    assign stage_out_ready = !mr_active && ((s_q.mwr - s_q.hcnt) < CW'(DEPTH));

    fwff_stage_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (STAGE_DEPTH)
    ) u_stage (
        .core_clk_in   (core_clk_in),
        .rst_in        (rst_in),
        .clear_in      (mr_active),
        .in_valid_in   (accept),
        .in_ready_out  (stage_in_ready),
        .in_data_in    (s_q.d2),
        .out_valid_out (stage_out_valid),
        .out_ready_in  (stage_out_ready),
        .out_data_out  (stage_out_data)
    );

    always_comb
    begin
        logic [2:0]  sel;
        logic        load;
        logic [31:0] rd;
        sel  = '0;
        load = 1'b0;
        rd   = '0;
        s_d  = s_q;

        s_d.p1        = pins;
        s_d.p2        = s_q.p1;
        s_d.d1        = write_data_in;
        s_d.d2        = s_q.d1;
        s_d.wclk_prev = s_q.p2.wclk;
        s_d.rclk_prev = s_q.p2.rclk;

        // write side
        if (accept)
        begin
            s_d.wcnt = s_q.wcnt + 1'b1;
        end
        if (stage_out_valid && stage_out_ready)
        begin
            s_d.mem[s_q.mwr[AW-1:0]] = stage_out_data;
            s_d.mwr                  = s_q.mwr + 1'b1;
        end
        if (wr_edge)
        begin
            s_d.rcnt_w1 = s_q.rcnt;
            s_d.rcnt_w2 = s_q.rcnt_w1;
        end

        // read side: two sync stages then the holding register make three
        if (rd_edge)
        begin
            s_d.wcnt_r1 = s_q.wcnt;
            s_d.wcnt_r2 = s_q.wcnt_r1;
            s_d.mwr_r1  = s_q.mwr;
            s_d.mwr_r2  = s_q.mwr_r1;
            if (rd_take)
            begin
                s_d.rcnt       = s_q.rcnt + 1'b1;
                s_d.hold_valid = 1'b0;
            end
            load = (!s_q.hold_valid || rd_take) && (s_q.mwr_r2 != s_q.hcnt);
            if (load)
            begin
                // first word falls through without a read request
                s_d.hold       = s_q.mem[s_q.hcnt[AW-1:0]];
                s_d.hold_valid = 1'b1;
                s_d.hcnt       = s_q.hcnt + 1'b1;
            end
            s_d.flags.or_n = !s_d.hold_valid;
            s_d.flags.ae_n = (count_r >= CW'(s_q.empty_ofs) + CW'(2));
        end

        // the holding register is part of the stored count
        s_d.flags.ir_n = (count_w >= CAP);
        s_d.flags.af_n = !(count_w >= CAP - CW'(s_q.full_ofs));
        s_d.flags.hf_n = !(count_w >= HALF_AT);

        // offsets reach the outside only through the parallel data output
        case (s_q.view)
            fwff_pkg::VIEW_EMPTY: s_d.q = WIDTH'(s_q.empty_ofs);
            fwff_pkg::VIEW_FULL:  s_d.q = WIDTH'(s_q.full_ofs);
            default:              s_d.q = s_d.hold;
        endcase

        // avalon slave: one wait cycle, write lands at the edge waitrequest is seen low
        case (s_q.bus)
            fwff_pkg::BUS_IDLE:
            begin
                s_d.waitreq = 1'b1;
                if (avs_read_in || avs_write_in)
                begin
                    case (avs_address_in)
                        fwff_pkg::REG_CTRL:
                            rd[fwff_pkg::CTRL_VIEW_LSB +: fwff_pkg::CTRL_VIEW_W] = s_q.view;
                        fwff_pkg::REG_STATUS:
                        begin
                            rd[fwff_pkg::ST_IR_N]   = s_q.flags.ir_n;
                            rd[fwff_pkg::ST_OR_N]   = s_q.flags.or_n;
                            rd[fwff_pkg::ST_HF_N]   = s_q.flags.hf_n;
                            rd[fwff_pkg::ST_AF_N]   = s_q.flags.af_n;
                            rd[fwff_pkg::ST_AE_N]   = s_q.flags.ae_n;
                            rd[fwff_pkg::ST_FALL_THROUGH_MODE]   = s_q.cfg.fall_through_mode;
                            rd[fwff_pkg::ST_SERIAL] = s_q.cfg.serial_load;
                        end
                        fwff_pkg::REG_COUNT:
                            rd = 32'(count_w);
                        default:
                            rd = '0;
                    endcase
                    s_d.rdata   = avs_read_in ? rd : '0;
                    s_d.waitreq = 1'b0;
                    s_d.bus     = fwff_pkg::BUS_ANS;
                end
            end
            fwff_pkg::BUS_ANS:
            begin
                s_d.waitreq = 1'b1;
                s_d.bus     = fwff_pkg::BUS_IDLE;
                if (avs_write_in)
                begin
                    case (avs_address_in)
                        fwff_pkg::REG_CTRL:
                            s_d.view = 2'(merge_be(32'(s_q.view), avs_writedata_in, avs_byteenable_in));
                        // stored as written: software keeps offsets below depth
                        fwff_pkg::REG_EMPTY_OFS:
                            s_d.empty_ofs = 16'(merge_be(32'(s_q.empty_ofs), avs_writedata_in,
                                                         avs_byteenable_in));
                        fwff_pkg::REG_FULL_OFS:
                            s_d.full_ofs = 16'(merge_be(32'(s_q.full_ofs), avs_writedata_in,
                                                        avs_byteenable_in));
                        default:
                            s_d.view = s_q.view;
                    endcase
                end
            end
            default:
            begin
                s_d.bus     = fwff_pkg::BUS_IDLE;
                s_d.waitreq = 1'b1;
            end
        endcase

        // master reset latches configuration and empties the fifo
        if (mr_active)
        begin
            s_d.cfg.fall_through_mode = s_q.p2.timing_mode_select;
            s_d.cfg.serial_load       = s_q.p2.offset_load_select;
            sel                       = {s_q.p2.offset_load_select, s_q.p2.offset_select_hi,
                                         s_q.p2.offset_select_lo};
            s_d.cfg.offset_sel        = sel[1:0];
            s_d.empty_ofs             = fwff_pkg::default_offset(sel[2], sel[1:0], DEEP);
            s_d.full_ofs              = fwff_pkg::default_offset(sel[2], sel[1:0], DEEP);
            {s_d.wcnt, s_d.mwr, s_d.hcnt, s_d.rcnt, s_d.rcnt_w1} = '0;
            {s_d.rcnt_w2, s_d.wcnt_r1, s_d.wcnt_r2, s_d.mwr_r1, s_d.mwr_r2} = '0;
            s_d.hold_valid            = 1'b0;
            s_d.flags                 = fwff_pkg::FLAGS_EMPTY;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            s_q                       <= '0;
            {s_q.p1.master_reset_n, s_q.p2.master_reset_n, s_q.p1.write_en_n} <= '1;
            {s_q.p2.write_en_n, s_q.p1.read_en_n, s_q.p2.read_en_n} <= '1;
            s_q.cfg.fall_through_mode <= fwff_pkg::RST_FALL_THROUGH_MODE;
            s_q.cfg.serial_load       <= fwff_pkg::RST_SERIAL;
            s_q.cfg.offset_sel        <= fwff_pkg::RST_SEL;
            s_q.empty_ofs             <= fwff_pkg::OFS_127;
            s_q.full_ofs              <= fwff_pkg::OFS_127;
            s_q.view                  <= fwff_pkg::VIEW_FIFO;
            s_q.flags                 <= fwff_pkg::FLAGS_EMPTY;
            s_q.bus                   <= fwff_pkg::BUS_IDLE;
            s_q.waitreq               <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign avs_readdata_out        = s_q.rdata;
    assign avs_waitrequest_out     = s_q.waitreq;
    assign read_data_out           = s_q.q;
    assign input_ready_n_out       = s_q.flags.ir_n;
    assign output_ready_n_out      = s_q.flags.or_n;
    assign half_full_flag_n_out    = s_q.flags.hf_n;
    assign almost_full_flag_n_out  = s_q.flags.af_n;
    assign almost_empty_flag_n_out = s_q.flags.ae_n;
endmodule : fwff_top

// [dv/fwff_assertions.sv]
// checker: register handshake and flag relations at the top ports
module fwff_assertions (
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    input wire logic        master_reset_n_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [4:0]  avs_address_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        input_ready_n_out,
    input wire logic        output_ready_n_out,
    input wire logic        half_full_flag_n_out,
    input wire logic        almost_full_flag_n_out,
    input wire logic        almost_empty_flag_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("no answer after request");
    a_bus_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer longer than one cycle");
    a_answer_cause: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
        else $error("answer without request");
    a_idle_rest: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer while idle");
    a_unmapped_zero: assert property (!avs_waitrequest_out && $past(avs_read_in) && $past(avs_address_in) == 5'h14
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    a_rdata_hold: assert property (avs_waitrequest_out && $past(avs_waitrequest_out) |-> $stable(avs_readdata_out))
        else $error("read data moved between answers");
    a_full_flags: assert property (input_ready_n_out |-> !output_ready_n_out && !almost_full_flag_n_out
        && !half_full_flag_n_out) else $error("full without other flags");
    a_mreset_empty: assert property ($fell(master_reset_n_in) |-> ##4 (!input_ready_n_out && output_ready_n_out
        && half_full_flag_n_out && !almost_empty_flag_n_out)) else $error("master reset not empty");
    c_full: cover property (input_ready_n_out);
    c_mreset: cover property ($fell(master_reset_n_in));
    c_write: cover property (!avs_waitrequest_out && $past(avs_write_in));
endmodule : fwff_assertions

bind fwff_top fwff_assertions u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .master_reset_n_in(master_reset_n_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_address_in(avs_address_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .input_ready_n_out(input_ready_n_out),
    .output_ready_n_out(output_ready_n_out), .half_full_flag_n_out(half_full_flag_n_out),
    .almost_full_flag_n_out(almost_full_flag_n_out), .almost_empty_flag_n_out(almost_empty_flag_n_out));

// [dv/fwff_link_model.sv]
// link partner: writer and reader agents on free-running clocks
module fwff_link_model (
    input  wire logic   core_clk_in,
    output logic        wclk_out,
    output logic        rclk_out,
    output logic        wen_n_out,
    output logic        ren_n_out,
    output logic [35:0] wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        {wclk_out, rclk_out, wen_n_out, ren_n_out} = 4'h3;
        wdata_out = 36'h0;
        #37;
        forever #100 rclk_out = ~rclk_out;
    end
    always #100 wclk_out = ~wclk_out;
    // one word per write edge; last releases the enable
    task automatic push(input logic [35:0] d, input logic last);
        @(negedge wclk_out);
        @(posedge core_clk_in);
        wdata_out <= d;
        wen_n_out <= 1'b0;
        if (last)
        begin
            @(negedge wclk_out);
            @(posedge core_clk_in);
            wen_n_out <= 1'b1;
            wdata_out <= ~d; // no stale word on a released bus
        end
    endtask : push
    task automatic pull(input logic last);
        @(negedge rclk_out);
        @(posedge core_clk_in);
        ren_n_out <= 1'b0;
        if (last)
        begin
            @(negedge rclk_out);
            @(posedge core_clk_in);
            ren_n_out <= 1'b1;
        end
    endtask : pull
endmodule : fwff_link_model

// [dv/fwff_top_tb.sv]
// testbench: fifo flags, default offsets, readback and register slave
module fwff_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, mr_n, tms, ld, shi, slo, rd, wr, wq, wclk, rclk, wen_n, ren_n, ir_n, or_n, hf_n, af_n, ae_n;
    logic [4:0]  addr;
    logic [31:0] wdat, rdat, r;
    logic [35:0] wd, q, d;
    logic [35:0] exp_q[$];
    logic [15:0] tbl[8] = '{16'h007f, 16'h00ff, 16'h01ff, 16'h003f, 16'h001f, 16'h0007, 16'h000f, 16'h0003};
    int          mismatches, total_checks, k, c;
    fwff_top #(.WIDTH(36), .DEPTH(16), .STAGE_DEPTH(4)) dut (.core_clk_in(clk), .rst_in(rst),
        .write_clk_in(wclk), .read_clk_in(rclk), .write_en_n_in(wen_n), .read_en_n_in(ren_n),
        .write_data_in(wd), .master_reset_n_in(mr_n), .timing_mode_select_in(tms), .offset_load_select_in(ld),
        .offset_select_hi_in(shi), .offset_select_lo_in(slo), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wq), .read_data_out(q), .input_ready_n_out(ir_n), .output_ready_n_out(or_n),
        .half_full_flag_n_out(hf_n), .almost_full_flag_n_out(af_n), .almost_empty_flag_n_out(ae_n));
    fwff_link_model lm (.core_clk_in(clk), .wclk_out(wclk), .rclk_out(rclk), .wen_n_out(wen_n),
        .ren_n_out(ren_n), .wdata_out(wd));
    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dv, output logic [31:0] rv);
        int n;
        @(posedge clk);
        addr <= a;
        wdat <= dv;
        rd <= !w;
        wr <= w;
        for (n = 0; n < 50 && wq !== 1'b0; n++)
            @(posedge clk);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50)
            mismatches++;
    endtask : bus
    task automatic mreset(input logic [3:0] s);
        @(posedge clk);
        {tms, ld, shi, slo} <= s;
        mr_n <= 1'b0;
        repeat (8) @(posedge clk);
        mr_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : mreset
    // offsets n=2 m=3 on 16 words: ae high from 4, hf low from 10, af low from 14, full at 17
    function automatic logic [35:0] est(input int n);
        return 36'({2'b01, n >= 4, n < 14, n < 10, n == 0, n >= 17});
    endfunction : est
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    always @(posedge rclk)
        if (ren_n === 1'b0 && or_n === 1'b0)
            chk("read_word", exp_q.size() > 0 ? exp_q.pop_front() : ~q, q);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #400000;
        mismatches++;
        finish_test();
    end
    initial
    begin
        {rst, mr_n, tms, ld, shi, slo, rd, wr, addr, wdat} = {3'b111, 42'h0};
        void'($urandom(26656));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 8; k++)
        begin
            mreset({k[1], 3'(k)});
            bus(1'b0, 5'h0c, 32'h0, r);
            chk("mode", 36'({k[2], k[1], 2'b10}), 36'({r[6:5], r[1:0]}));
            for (c = 1; c < 3; c++)
            begin
                bus(1'b1, 5'h00, 32'(c), r);
                repeat (3) @(posedge clk);
                chk("offset", 36'(tbl[k]), 36'(q[15:0]));
            end
        end
        mreset(4'h8);
        bus(1'b1, 5'h04, 32'h2, r);
        bus(1'b1, 5'h08, 32'h3, r);
        bus(1'b1, 5'h00, 32'h0, r);
        bus(1'b1, 5'h0c, 32'hffffffff, r);
        bus(1'b0, 5'h14, 32'h0, r);
        chk("unmapped", 36'h0, 36'(r));
        for (k = 0; k < 37; k++)
        begin
            d = 36'({$urandom(), $urandom()});
            if (k > 18)
                lm.pull(1'b1);
            else if (k > 0)
                lm.push(d, 1'b1);
            if (k > 0 && k < 18)
                exp_q.push_back(d);
            c = (k <= 18) ? ((k > 17) ? 17 : k) : ((35 - k > 0) ? 35 - k : 0);
            repeat (48) @(posedge clk);
            bus(1'b0, 5'h0c, 32'h0, r);
            chk("status", est(c), 36'(r[6:0]));
            bus(1'b0, 5'h10, 32'h0, r);
            chk("count", 36'(c), 36'(r));
        end
        for (k = 0; k < 6; k++)
        begin
            d = 36'({$urandom(), $urandom()});
            exp_q.push_back(d);
            lm.push(d, k == 5);
        end
        repeat (48) @(posedge clk);
        for (k = 0; k < 6; k++)
            lm.pull(k == 5);
        repeat (48) @(posedge clk);
        chk("leftover", 36'h0, 36'(exp_q.size()));
        finish_test();
    end
endmodule : fwff_top_tb
